/* File: logic/dspci_top.sv */
/*
 * dspci_top: start, dwell, stall fault and totaliser logic of a fluid
 * dispense controller's machine interface.
 * assumes asynchronous pins from the machine and front panel; the far
 * side drives start pulses of 10 to 100 ms.
 */
//
// Behaviour
// - start on rising edge when unfaulted
// - ignore start input while operation runs
// - idle output true only when ready, unfaulted
// - fault output active low, low when faulted
// - fault only after four second stall
// - switches conduct when signal true
// - idle contact closed only when ready
// - no contact closed unfaulted, nc when faulted
// - foot switch held retriggers each cycle
// - dwell wait ignores all start pulses
// - dwell maps linearly 0.5 s to 2 s over settings 0 to 999
// - fixed 50 ms dwell without option
// - totaliser counts only forward metered revolutions
// - totaliser reset button clears count
// - no revolution in four seconds faults
// - reset button clears fault and state
// - metered run stops at revolution count
`timescale 1ns/100ps
`default_nettype none
module dspci_top
  import dspci_pkg::*;
#(
  parameter int STALL_CYCLES = dspci_pkg::STALL_CYC,
  parameter int DWELL_FIX_CYCLES = dspci_pkg::DWELL_FIXED_CYC,
  parameter int DWELL_BASE_CYCLES = dspci_pkg::DWELL_MIN_CYC,
  parameter int DWELL_STEP_CYCLES = dspci_pkg::DWELL_STEP_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start_pulse,
  input wire logic rev_sense,
  input wire logic fault_reset_btn,
  input wire logic total_reset_btn,
  input wire logic foot_switch,
  input wire logic metered_cycle_mode,
  input wire logic direction_select,
  input wire logic adj_dwell_en,
  input wire logic [dspci_pkg::SET_W-1:0] dwell_setting,
  input wire logic [dspci_pkg::SET_W-1:0] rev_count_setting,
  output logic motor_run,
  output logic idle_out,
  output logic stall_alarm_b,
  output logic reset_lamp,
  output logic idle_contact,
  output logic fault_no_contact,
  output logic fault_nc_contact,
  output logic [dspci_pkg::TOT_W-1:0] total_count
);
  import dspci_pkg::*;

  logic [1:0] rst_sync_r;
  logic rst_i_b;
  logic [4:0] pin_s;
  logic start_s, rev_s, frst_s, trst_s, foot_s;
  logic [2*SET_W+2:0] cfg_s;
  logic meter_s, dir_s, adj_s;
  logic [SET_W-1:0] dwell_set_s, rev_set_s;
  logic start_d_r, rev_d_r;
  logic start_rise, rev_rise;
  dspci_state_t state_r;
  logic [CNT_W-1:0] stall_cnt_r;
  logic [CNT_W-1:0] dwell_cnt_r;
  logic [SET_W-1:0] rev_cnt_r;
  logic [CNT_W-1:0] dwell_len;
  logic stall_hit, run_done;

  // reset released through two flops
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_r <= SYNC_RST;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_i_b = rst_sync_r[1];

  dspci_sync #(.W(5)) u_sync (
    .clock(clock),
    .rst_b(rst_i_b),
    .d({start_pulse, rev_sense, fault_reset_btn, total_reset_btn,
        foot_switch}),
    .q(pin_s)
  );
  assign {start_s, rev_s, frst_s, trst_s, foot_s} = pin_s;

  // panel switches are quasi-static; a word changed mid-cycle may show
  // mixed bits for one cycle, so change settings only while idle
  dspci_sync #(.W(2*SET_W+3)) u_sync_cfg (
    .clock(clock),
    .rst_b(rst_i_b),
    .d({metered_cycle_mode, direction_select, adj_dwell_en, dwell_setting,
        rev_count_setting}),
    .q(cfg_s)
  );
  assign {meter_s, dir_s, adj_s, dwell_set_s, rev_set_s} = cfg_s;

  always_ff @(posedge clock or negedge rst_i_b)
  begin
    if (!rst_i_b)
    begin
      start_d_r <= 1'b0;
      rev_d_r <= 1'b0;
    end
    else
    begin
      start_d_r <= start_s;
      rev_d_r <= rev_s;
    end
  end
  assign start_rise = start_s & ~start_d_r;
  assign rev_rise = rev_s & ~rev_d_r;

  always_comb
  begin
    if (adj_s)
      dwell_len = CNT_W'(DWELL_BASE_CYCLES) +
        CNT_W'(dwell_set_s) * CNT_W'(DWELL_STEP_CYCLES);
    else
      dwell_len = CNT_W'(DWELL_FIX_CYCLES);
  end

  assign stall_hit = stall_cnt_r >= CNT_W'(STALL_CYCLES - 1);
  // prime mode runs until metered mode is selected and count reached
  assign run_done = meter_s && rev_rise &&
    (rev_cnt_r + 10'h001 >= rev_set_s);

  always_ff @(posedge clock or negedge rst_i_b)
  begin
    if (!rst_i_b)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
          if (start_rise || foot_s)
            state_r <= ST_RUN;
        ST_RUN:
          // start input not looked at here
          if (stall_hit)
            state_r <= ST_FAULT;
          else if (run_done)
            state_r <= ST_DWELL;
        ST_DWELL:
          if (dwell_cnt_r + 32'h0000_0001 >= dwell_len)
            state_r <= foot_s ? ST_RUN : ST_IDLE;
        ST_FAULT:
          if (frst_s)
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // stall window restarts on every revolution
  always_ff @(posedge clock or negedge rst_i_b)
  begin
    if (!rst_i_b)
      stall_cnt_r <= '0;
    else if (state_r != ST_RUN || rev_rise)
      stall_cnt_r <= '0;
    else
      stall_cnt_r <= stall_cnt_r + 32'h0000_0001;
  end

  always_ff @(posedge clock or negedge rst_i_b)
  begin
    if (!rst_i_b)
      rev_cnt_r <= '0;
    else if (state_r != ST_RUN)
      rev_cnt_r <= '0;
    else if (rev_rise)
      rev_cnt_r <= rev_cnt_r + 10'h001;
  end

  always_ff @(posedge clock or negedge rst_i_b)
  begin
    if (!rst_i_b)
      dwell_cnt_r <= '0;
    else if (state_r != ST_DWELL)
      dwell_cnt_r <= '0;
    else
      dwell_cnt_r <= dwell_cnt_r + 32'h0000_0001;
  end

  // reset wins over a revolution in the same cycle
  always_ff @(posedge clock or negedge rst_i_b)
  begin
    if (!rst_i_b)
      total_count <= '0;
    else if (trst_s)
      total_count <= '0;
    else if (rev_rise && state_r == ST_RUN && meter_s && !dir_s)
      total_count <= total_count + 24'h00_0001;
  end

  always_ff @(posedge clock or negedge rst_i_b)
  begin
    if (!rst_i_b)
    begin
      motor_run <= 1'b0;
      idle_out <= 1'b0;
      stall_alarm_b <= 1'b0;
      reset_lamp <= 1'b0;
      idle_contact <= 1'b0;
      fault_no_contact <= 1'b0;
      fault_nc_contact <= 1'b1;
    end
    else
    begin
      motor_run <= state_r == ST_RUN;
      idle_out <= state_r == ST_IDLE;
      stall_alarm_b <= state_r != ST_FAULT;
      reset_lamp <= state_r == ST_FAULT;
      idle_contact <= state_r == ST_IDLE;
      fault_no_contact <= state_r != ST_FAULT;
      fault_nc_contact <= state_r == ST_FAULT;
    end
  end

  sequence s_stalled;
    state_r == ST_RUN && stall_hit;
  endsequence

  AST_FAULT_ON_STALL: assert property (@(posedge clock) disable iff (!rst_i_b)
    s_stalled |=> state_r == ST_FAULT ##1 !stall_alarm_b && reset_lamp)
    else $error("stall did not fault");
  AST_START_EDGE: assert property (@(posedge clock) disable iff (!rst_i_b)
    state_r == ST_IDLE && start_rise |=> state_r == ST_RUN)
    else $error("start edge ignored");
  AST_NO_START_FAULT: assert property (@(posedge clock) disable iff (!rst_i_b)
    state_r == ST_FAULT && !frst_s |=> state_r == ST_FAULT)
    else $error("left fault without reset");
  AST_RUN_IGNORES: assert property (@(posedge clock) disable iff (!rst_i_b)
    state_r == ST_RUN && !stall_hit && !run_done |=> state_r == ST_RUN)
    else $error("run left early");
  AST_IDLE_OUT: assert property (@(posedge clock) disable iff (!rst_i_b)
    idle_out |-> $past(state_r) == ST_IDLE && stall_alarm_b)
    else $error("idle out while busy");
  AST_CONTACTS: assert property (@(posedge clock) disable iff (!rst_i_b)
    fault_no_contact != fault_nc_contact && idle_contact == idle_out &&
    stall_alarm_b == fault_no_contact)
    else $error("contact pair wrong");
  AST_DWELL_HOLD: assert property (@(posedge clock) disable iff (!rst_i_b)
    $rose(state_r == ST_DWELL) |-> (state_r == ST_DWELL) [*3])
    else $error("dwell too short");
  AST_TOT_CLEAR: assert property (@(posedge clock) disable iff (!rst_i_b)
    trst_s |=> total_count == '0)
    else $error("totaliser not cleared");
  AST_TOT_REV: assert property (@(posedge clock) disable iff (!rst_i_b)
    dir_s && !trst_s |=> $stable(total_count))
    else $error("counted in reverse");
endmodule : dspci_top
`default_nettype wire

/* File: shared/dspci_pkg.sv */
/*
 * dspci_pkg: constants for the dispense controller machine interface.
 * assumes a 250 MHz system clock; all times are converted here.
 */
`default_nettype none
package dspci_pkg;
  localparam int CLK_MHZ = 250;
  // stall window and dwell times in their own units
  localparam int STALL_S = 4;
  localparam int DWELL_FIXED_MS = 50;
  localparam int DWELL_MIN_MS = 500;
  localparam int DWELL_MAX_MS = 2000;
  localparam int DWELL_SET_MAX = 999;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int STALL_CYC = STALL_S * 1000 * CYC_PER_MS;
  localparam int DWELL_FIXED_CYC = DWELL_FIXED_MS * CYC_PER_MS;
  localparam int DWELL_MIN_CYC = DWELL_MIN_MS * CYC_PER_MS;
  // per-step increase; 999 steps span 0.5 s to 2 s
  localparam int DWELL_STEP_CYC =
    ((DWELL_MAX_MS - DWELL_MIN_MS) * CYC_PER_MS) / DWELL_SET_MAX;
  localparam int SET_W = 10;
  localparam int TOT_W = 24;
  localparam int CNT_W = 32;
  localparam logic [1:0] SYNC_RST = 2'h0;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_RUN   = 4'h2,
    ST_DWELL = 4'h4,
    ST_FAULT = 4'h8
  } dspci_state_t;
endpackage : dspci_pkg
`default_nettype wire

/* File: logic/dspci_sync.sv */
/*
 * dspci_sync: two-flop synchroniser, one per bit of the bus.
 * assumes inputs are asynchronous to clock.
 */
`timescale 1ns/100ps
`default_nettype none
module dspci_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_r[i] <= 1'b0;
          q[i] <= 1'b0;
        end
        else
        begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule : dspci_sync
`default_nettype wire

/* File: verif/dspci_plc_model.sv */
/*
 * dspci_plc_model: machine controller and spindle sensor stand-in.
 * assumes the bench calls fire() and drives at falling edges only.
 */
`timescale 1ns/100ps
`default_nettype none
module dspci_plc_model (
  input wire logic clock,
  input wire logic motor_run,
  input wire logic rev_en,
  output logic start_pulse,
  output logic rev_sense
);
  logic [2:0] ph_r = 3'h0;
  initial start_pulse = 1'b0;
  // rising edge, then held; widths scaled to cycles
  task automatic fire(input int w);
    @(negedge clock);
    start_pulse = 1'b1;
    repeat (w) @(negedge clock);
    start_pulse = 1'b0;
  endtask : fire
  // one revolution per 8 cycles while the spindle turns
  always @(negedge clock)
    ph_r <= (motor_run && rev_en) ? ph_r + 3'h1 : 3'h0;
  assign rev_sense = ph_r[2];
endmodule : dspci_plc_model
`default_nettype wire

/* File: verif/tb_dspci_top.sv */
/*
 * tb_dspci_top: cycle, dwell, totaliser, retrigger and stall tests.
 * assumes shortened stall and dwell counts set at the instance.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_dspci_top;
  import dspci_pkg::*;
  localparam int STALL = 200;
  localparam int DFIX = 20;
  logic clock = 0, rst_b = 0, start_pulse, rev_sense, rev_en = 1;
  logic fault_reset_btn = 0, total_reset_btn = 0, foot_switch = 0;
  logic metered_cycle_mode = 1, direction_select = 0, adj_dwell_en = 0;
  logic [SET_W-1:0] dwell_setting = 10'h0, rev_count_setting = 10'h3;
  logic motor_run, idle_out, stall_alarm_b, reset_lamp, idle_contact;
  logic fault_no_contact, fault_nc_contact;
  logic [TOT_W-1:0] total_count;
  int err_count = 0, comparisons = 0;
  always #2 clock = ~clock;
  dspci_plc_model i_dspci_plc_model (.clock(clock), .motor_run(motor_run),
    .rev_en(rev_en), .start_pulse(start_pulse), .rev_sense(rev_sense));
  dspci_top #(.STALL_CYCLES(STALL), .DWELL_FIX_CYCLES(DFIX),
    .DWELL_BASE_CYCLES(30), .DWELL_STEP_CYCLES(1)) i_dspci_top (
    .clock(clock), .rst_b(rst_b), .start_pulse(start_pulse),
    .rev_sense(rev_sense), .fault_reset_btn(fault_reset_btn),
    .total_reset_btn(total_reset_btn), .foot_switch(foot_switch),
    .metered_cycle_mode(metered_cycle_mode),
    .direction_select(direction_select), .adj_dwell_en(adj_dwell_en),
    .dwell_setting(dwell_setting), .rev_count_setting(rev_count_setting),
    .motor_run(motor_run), .idle_out(idle_out),
    .stall_alarm_b(stall_alarm_b), .reset_lamp(reset_lamp),
    .idle_contact(idle_contact), .fault_no_contact(fault_no_contact),
    .fault_nc_contact(fault_nc_contact), .total_count(total_count));
  task automatic chk(input logic [TOT_W-1:0] g, input logic [TOT_W-1:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic till(input logic v);
    int i;
    i = 0;
    while (motor_run !== v && i < 3000)
    begin
      @(negedge clock);
      i++;
    end
    chk(motor_run, v);
  endtask : till
  // one triggered cycle with stray pulses in run and in dwell
  task automatic cyc(input int dl);
    int n;
    i_dspci_plc_model.fire(6);
    chk(motor_run, 1);
    chk({idle_out, idle_contact}, 2'h0);
    fork i_dspci_plc_model.fire(4); join_none
    till(0);
    fork i_dspci_plc_model.fire(4); join_none
    n = 0;
    while (idle_out !== 1'b1 && n < 1100)
    begin
      @(negedge clock);
      n++;
    end
    chk(n >= dl - 1 && n <= dl + 1, 1);
    chk(motor_run, 0);
  endtask : cyc
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #100000;
    err_count++;
    report_and_stop;
  end
  initial
  begin
    repeat (5) @(negedge clock);
    rst_b = 1;
    repeat (8) @(negedge clock);
    chk({idle_out, idle_contact, stall_alarm_b}, 3'h7);
    chk({fault_no_contact, fault_nc_contact}, 2'h2);
    $display("test reset done");
    cyc(DFIX);
    chk(total_count, 3);
    adj_dwell_en = 1;
    cyc(30);
    dwell_setting = 10'h3e7;
    cyc(1029);
    chk(total_count, 9);
    $display("test metered and dwell done");
    adj_dwell_en = 0;
    direction_select = 1;
    cyc(DFIX);
    chk(total_count, 9);
    direction_select = 0;
    total_reset_btn = 1;
    repeat (4) @(negedge clock);
    total_reset_btn = 0;
    chk(total_count, 0);
    rev_count_setting = 10'h0;
    i_dspci_plc_model.fire(6);
    till(0);
    chk(total_count, 1);
    repeat (DFIX + 4) @(negedge clock);
    chk(idle_out, 1);
    rev_count_setting = 10'h3;
    $display("test totaliser done");
    foot_switch = 1;
    till(1);
    till(0);
    till(1);
    foot_switch = 0;
    till(0);
    repeat (DFIX + 10) @(negedge clock);
    chk(motor_run, 0);
    chk(total_count, 7);
    $display("test retrigger done");
    metered_cycle_mode = 0;
    i_dspci_plc_model.fire(6);
    repeat (40) @(negedge clock);
    chk({motor_run, idle_out}, 2'h2);
    chk(total_count, 7);
    metered_cycle_mode = 1;
    till(0);
    repeat (DFIX + 10) @(negedge clock);
    $display("test prime done");
    rev_en = 0;
    metered_cycle_mode = 0;
    i_dspci_plc_model.fire(6);
    repeat (STALL - 40) @(negedge clock);
    chk(stall_alarm_b, 1);
    repeat (60) @(negedge clock);
    chk({stall_alarm_b, reset_lamp, idle_out}, 3'h2);
    chk({fault_no_contact, fault_nc_contact}, 2'h1);
    i_dspci_plc_model.fire(6);
    repeat (4) @(negedge clock);
    chk({motor_run, idle_contact}, 2'h0);
    fault_reset_btn = 1;
    repeat (4) @(negedge clock);
    fault_reset_btn = 0;
    repeat (6) @(negedge clock);
    chk({idle_out, reset_lamp, stall_alarm_b}, 3'h5);
    $display("test stall fault done");
    report_and_stop;
  end
endmodule : tb_dspci_top
`default_nettype wire
